// ==== led_seq_pkg.sv ====
// package: constants for the led display and mode sequencer
package led_seq_pkg;
  localparam int CLK_MHZ = 200;
  localparam int TICK_US = 134;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam int REFRESH_MS = 500;
  localparam int REFRESH_CYCLES = REFRESH_MS * 1000 * CLK_MHZ;
  localparam int CONV_NS = 11375;
  localparam int CONV_CYCLES = (CONV_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] SEL_GAUGE = 8'h0E;
  localparam logic [7:0] SEL_MODE = 8'h0D;
  localparam logic [7:0] SEL_OFF = 8'h0F;
  localparam logic [4:0] DATA_OFF = 5'h00;
  localparam logic [7:0] BAT_REF_CFG = 8'h80;
  localparam logic [7:0] ILL_REF_CFG = 8'h00;
  localparam logic [4:0] ILL_CHANNEL = 5'h11;
  localparam logic [4:0] BAT_CHANNEL = 5'h10;
  localparam logic [7:0] ILL_TABLE_HI = 8'hFB;
  localparam logic [7:0] BAT_TABLE_HI = 8'hFA;
  localparam logic [4:0] ILL_MODE_LED = 5'h01;
  localparam logic [4:0] BAT_MODE_LED = 5'h02;
  typedef enum logic [1:0] {PH_GAUGE, PH_DARK1, PH_MODE, PH_DARK2} phase_type;
  typedef enum logic {MEAS_ILL, MEAS_BAT} meas_type;
endpackage : led_seq_pkg

// ==== interval_ticker.sv ====
// module: interval counter, counting only while run is high, with a one-cycle expiry pulse
`timescale 1ns/100ps
`default_nettype none
module interval_ticker #(
  parameter int PERIOD = 26800
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic run,
  output logic tick
);
  logic [31:0] countReg;
  // ----------------------------------------
  // counter
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst || !run) begin
      countReg <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (countReg == 32'(PERIOD - 1)) begin
      countReg <= 32'h0000_0000;
      tick <= 1'b1;
    end else begin
      countReg <= countReg + 32'h0000_0001;
      tick <= 1'b0;
    end
  end
endmodule : interval_ticker
`default_nettype wire

// ==== led_display_mode_sequencer.sv ====
// module: led scan, switch mode toggle, refresh and converter trigger timing
`timescale 1ns/100ps
`default_nettype none
module led_display_mode_sequencer #(
  parameter int TICK_PERIOD = led_seq_pkg::TICK_CYCLES,
  parameter int REFRESH_PERIOD = led_seq_pkg::REFRESH_CYCLES,
  parameter int CONV_PERIOD = led_seq_pkg::CONV_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic switchPin,
  input wire logic [4:0] gaugePattern,
  output logic [7:0] groupSelectPort,
  output logic [4:0] displayDataPort,
  output logic [7:0] refConfig,
  output logic [4:0] channelSelect,
  output logic [7:0] tableHighByte,
  output logic measIsBattery,
  output logic converterTrigger,
  output logic converterBusy,
  output logic refreshStart
);
  import led_seq_pkg::*;

  logic displayTick;
  logic refreshTick;
  logic trigTick;
  logic trigRunReg;
  phase_type phaseReg;
  meas_type measReg;
  logic [4:0] modeLedReg;
  logic [4:0] pendingDataReg;
  logic dataPendingReg;
  logic switchPrevReg;
  logic [31:0] convCountReg;
  logic switchRise;
  logic [31:0] busyLenReg;

  // ----------------------------------------
  // interval timers
  // ----------------------------------------
  // display tick timer
  interval_ticker #(.PERIOD(TICK_PERIOD)) displayTimer (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(1'b1),
    .tick(displayTick)
  );
  // refresh timer
  interval_ticker #(.PERIOD(REFRESH_PERIOD)) refreshTimer (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(1'b1),
    .tick(refreshTick)
  );
  // converter trigger timer runs only between refresh and conversion start
  interval_ticker #(.PERIOD(TICK_PERIOD)) trigTimer (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(trigRunReg),
    .tick(trigTick)
  );

  // ----------------------------------------
  // display scan
  // ----------------------------------------
  function automatic logic [7:0] selFor(input phase_type ph);
    case (ph)
      PH_GAUGE: selFor = SEL_GAUGE;
      PH_MODE: selFor = SEL_MODE;
      default: selFor = SEL_OFF;
    endcase
  endfunction : selFor

  // select written on the tick, phase advances
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phaseReg <= PH_GAUGE;
      groupSelectPort <= SEL_OFF; // leds off before any tick
    end else if (displayTick) begin
      groupSelectPort <= selFor(phaseReg);
      phaseReg <= phase_type'(phaseReg + 2'd1);
    end
  end

  // pattern captured on the tick, written one cycle after the select
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pendingDataReg <= DATA_OFF;
      dataPendingReg <= 1'b0;
      displayDataPort <= DATA_OFF;
    end else begin
      dataPendingReg <= displayTick;
      if (displayTick) begin
        case (phaseReg)
          PH_GAUGE: pendingDataReg <= gaugePattern;
          PH_MODE: pendingDataReg <= modeLedReg;
          default: pendingDataReg <= DATA_OFF;
        endcase
      end
      if (dataPendingReg) begin
        displayDataPort <= pendingDataReg;
      end
    end
  end

  // ----------------------------------------
  // switch and mode record
  // ----------------------------------------
  assign switchRise = switchPin && !switchPrevReg;

  // toggle measurement and load the whole record at once
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      switchPrevReg <= 1'b0;
      measReg <= MEAS_ILL;
      refConfig <= ILL_REF_CFG;
      channelSelect <= ILL_CHANNEL;
      tableHighByte <= ILL_TABLE_HI;
      modeLedReg <= ILL_MODE_LED;
      measIsBattery <= 1'b0;
    end else begin
      switchPrevReg <= switchPin;
      if (switchRise) begin
        if (measReg == MEAS_ILL) begin
          measReg <= MEAS_BAT;
          refConfig <= BAT_REF_CFG;
          channelSelect <= BAT_CHANNEL;
          tableHighByte <= BAT_TABLE_HI;
          modeLedReg <= BAT_MODE_LED;
          measIsBattery <= 1'b1;
        end else begin
          measReg <= MEAS_ILL;
          refConfig <= ILL_REF_CFG;
          channelSelect <= ILL_CHANNEL;
          tableHighByte <= ILL_TABLE_HI;
          modeLedReg <= ILL_MODE_LED;
          measIsBattery <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // measurement cycle
  // ----------------------------------------
  // one-shot: trigger waits on the timer, busy lasts one conversion time
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      trigRunReg <= 1'b0;
      converterTrigger <= 1'b0;
      converterBusy <= 1'b0;
      convCountReg <= 32'h0000_0000;
      refreshStart <= 1'b0;
    end else begin
      refreshStart <= refreshTick;
      converterTrigger <= trigTick;
      if (refreshTick && !converterBusy) begin
        trigRunReg <= 1'b1;
      end else if (trigTick) begin
        trigRunReg <= 1'b0; // timer stopped after one trigger, one-shot
      end
      if (trigTick) begin
        converterBusy <= 1'b1;
        convCountReg <= 32'(CONV_PERIOD - 1);
      end else if (converterBusy) begin
        if (convCountReg == 32'h0000_0000) begin
          converterBusy <= 1'b0;
        end else begin
          convCountReg <= convCountReg - 32'h0000_0001;
        end
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // helper: counts busy cycles, since a repetition of the full conversion time would be far too long
  always_ff @(posedge clk) begin
    if (sys_rst || !converterBusy) begin
      busyLenReg <= 32'h0000_0000;
    end else begin
      busyLenReg <= busyLenReg + 32'h0000_0001;
    end
  end

  chk_data_after_sel: assert property (@(posedge clk) disable iff (sys_rst)
    displayTick |=> ##1 (displayDataPort == $past(pendingDataReg)))
    else $error("data port not written one cycle after select");
  chk_gauge_data: assert property (@(posedge clk) disable iff (sys_rst)
    displayTick && phaseReg == PH_GAUGE |=> ##1 (displayDataPort == $past(gaugePattern, 2)))
    else $error("gauge pattern not shown after gauge select");
  chk_phase_step: assert property (@(posedge clk) disable iff (sys_rst)
    displayTick |=> (phaseReg == phase_type'($past(phaseReg) + 2'd1)))
    else $error("phase did not advance");
  chk_sel_code: assert property (@(posedge clk) disable iff (sys_rst)
    displayTick && phaseReg == PH_MODE |=> groupSelectPort == SEL_MODE)
    else $error("mode phase select code wrong");
  chk_gauge_code: assert property (@(posedge clk) disable iff (sys_rst)
    displayTick && phaseReg == PH_GAUGE |=> groupSelectPort == SEL_GAUGE)
    else $error("gauge phase select code wrong");
  chk_rise_toggle: assert property (@(posedge clk) disable iff (sys_rst)
    switchRise |=> measIsBattery != $past(measIsBattery))
    else $error("mode did not toggle on rising edge");
  chk_fall_ignored: assert property (@(posedge clk) disable iff (sys_rst)
    !switchRise |=> $stable(measIsBattery))
    else $error("mode changed without rising edge");
  chk_record_match: assert property (@(posedge clk) disable iff (sys_rst)
    measIsBattery |-> tableHighByte == BAT_TABLE_HI && channelSelect == BAT_CHANNEL)
    else $error("battery record incomplete");
  chk_busy_length: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(converterBusy) |-> (busyLenReg == 32'(CONV_PERIOD)))
    else $error("conversion busy time wrong");
endmodule : led_display_mode_sequencer
`default_nettype wire

// ==== switch_model.sv ====
// push switch model: clean press of fixed length on request
`timescale 1ns/100ps
`default_nettype none
module switch_model #(
  parameter int HOLD = 2
) (
  input wire logic clk,
  input wire logic press,
  output logic switchPin
);
  int held = 0;
  // no bounce: pin is high for HOLD cycles, then low again
  always @(posedge clk) begin
    if (press && held == 0) held <= HOLD;
    else if (held > 0) held <= held - 1;
    switchPin <= (held > 1) || (press && held == 0);
  end
endmodule : switch_model
`default_nettype wire

// ==== tb.sv ====
// testbench: display scan, mode toggling, refresh and converter timing
`timescale 1ns/100ps
`default_nettype none
module tb;
  import led_seq_pkg::*;
  localparam int TP = 8;
  localparam int RP = 50;
  localparam int CP = 4;
  logic clk = 0, sysRst = 1, press = 0, switchPin;
  logic [4:0] gaugePattern = 5'h00, displayDataPort, channelSelect;
  logic [7:0] groupSelectPort, refConfig, tableHighByte, lfsrState = 8'h2D, prevSel;
  logic measIsBattery, converterTrigger, converterBusy, refreshStart, dataDue;
  logic [12:0] expQ[$];
  logic [12:0] cur;
  int failures = 0, checks = 0, gap, n, w;
  always #2.5 clk = ~clk;
  led_display_mode_sequencer #(.TICK_PERIOD(TP), .REFRESH_PERIOD(RP), .CONV_PERIOD(CP)) DUT (.clk(clk),
    .sys_rst(sysRst), .switchPin(switchPin), .gaugePattern(gaugePattern), .groupSelectPort(groupSelectPort),
    .displayDataPort(displayDataPort), .refConfig(refConfig), .channelSelect(channelSelect),
    .tableHighByte(tableHighByte), .measIsBattery(measIsBattery), .converterTrigger(converterTrigger),
    .converterBusy(converterBusy), .refreshStart(refreshStart));
  switch_model #(.HOLD(2)) partner (.clk(clk), .press(press), .switchPin(switchPin));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic print_verdict;
    if (failures == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  // ----------------------------------------
  // scan monitor: oldest note is compared when a new select code shows
  // ----------------------------------------
  always @(posedge clk) begin
    if (dataDue) check(8'(displayDataPort), 8'(cur[4:0]));
    dataDue <= 1'b0;
    if (gap >= 0) gap <= gap + 1; // held negative until the first select change
    if (!sysRst && groupSelectPort !== prevSel && expQ.size() > 0) begin
      cur = expQ.pop_front();
      check(groupSelectPort, cur[12:5]);
      if (gap >= 0) check(8'(gap), 8'(TP));
      dataDue <= 1'b1;
      gap <= 1;
    end
    prevSel <= groupSelectPort;
  end
  // ----------------------------------------
  // refresh, converter trigger and busy window
  // ----------------------------------------
  always begin
    @(posedge clk iff refreshStart === 1'b1);
    w = 0;
    while (converterTrigger !== 1'b1 && w < 200) begin
      @(posedge clk);
      w++;
    end
    check(8'(w), 8'(TP + 1));
    w = 0;
    while (converterBusy === 1'b1 && w < 200) begin
      @(posedge clk);
      w++;
    end
    check(8'(w), 8'(CP));
  end
  // watchdog: the scan needs some 300 cycles, so 20000 means a hang
  initial begin
    #100000;
    failures++;
    print_verdict();
  end
  // ----------------------------------------
  // driver: reset, then rounds of four phases with a press between them
  // ----------------------------------------
  initial begin
    logic bat;
    bat = 1'b0;
    dataDue = 1'b0;
    gap = -1;
    prevSel = 8'h0F;
    repeat (20) @(negedge clk);
    check(groupSelectPort, SEL_OFF);
    check(8'(displayDataPort), 8'(DATA_OFF));
    check(8'(measIsBattery), 8'h00);
    for (int r = 0; r < 8; r++) begin
      lfsrState = lfsr(lfsrState);
      gaugePattern = lfsrState[4:0];
      expQ.push_back({SEL_GAUGE, gaugePattern});
      expQ.push_back({SEL_OFF, DATA_OFF});
      expQ.push_back({SEL_MODE, bat ? BAT_MODE_LED : ILL_MODE_LED});
      expQ.push_back({SEL_OFF, DATA_OFF});
      if (r == 0) sysRst = 1'b0;
      n = 0;
      while (expQ.size() > 0 && n < 300) begin
        @(negedge clk);
        n++;
      end
      if (expQ.size() > 0) failures++; // scan stalled: notes left unanswered
      // press in the dark slot; release edge must leave the mode alone
      press = 1'b1;
      @(negedge clk);
      press = 1'b0;
      bat = ~bat;
      repeat (4) @(negedge clk);
      check(8'(measIsBattery), 8'(bat));
      check(refConfig, bat ? BAT_REF_CFG : ILL_REF_CFG);
      check(8'(channelSelect), 8'(bat ? BAT_CHANNEL : ILL_CHANNEL));
      check(tableHighByte, bat ? BAT_TABLE_HI : ILL_TABLE_HI);
    end
    repeat (4) @(negedge clk);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
